// file: design/core_switch_timer.sv
`timescale 1ns/1ps
module core_switch_timer (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic arm_i,
  input wire logic trigger_i,
  output logic pending_o,
  output logic switch_o
);
  import mode_cfg_pkg::*;

  logic [CNT_W-1:0] cnt_reg; // Sample clocks since the trigger
  logic busy_reg; // Switch scheduled

  // A trigger while a switch is scheduled is ignored, so the
  // delay is always measured from the first trigger
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= '0;
      busy_reg <= 1'b0;
      switch_o <= 1'b0;
    end else if (ce_i) begin
      switch_o <= 1'b0;
      if (!arm_i) begin
        // Disarming cancels a scheduled switch
        busy_reg <= 1'b0;
        cnt_reg <= '0;
      end else if (!busy_reg) begin
        busy_reg <= trigger_i;
        cnt_reg <= '0;
      end else if (cnt_reg == SWITCH_DELAY - 1'b1) begin
        busy_reg <= 1'b0;
        switch_o <= 1'b1;
      end else begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end

  assign pending_o = busy_reg;

endmodule // core_switch_timer

// file: design/link_mode_table.sv
`timescale 1ns/1ps
module link_mode_table (
  input wire logic [mode_cfg_pkg::MODE_W-1:0] mode_i,
  output logic valid_o,
  output logic enc64_o,
  output logic [7:0] lanes_o,
  output logic [7:0] conv_o,
  output logic [7:0] octets_o,
  output logic [7:0] samples_o,
  output logic [7:0] res_o,
  output logic [7:0] bits_o,
  output logic [7:0] k64_o,
  output logic [mode_cfg_pkg::R_W-1:0] r_x16_o
);
  import mode_cfg_pkg::*;

  // Packed row: valid enc64 L M F S N N' K64 R
  logic [66:0] row;

  // Decode of the supported modes; unknown codes give an empty row
  always_comb begin
    case (mode_i)
      4'h0: row = {2'b10, 48'h08_08_08_05_0C_0C, 8'h00, 9'd128};
      4'h1: row = {2'b10, 48'h06_04_02_02_0C_0C, 8'h00, 9'd160};
      4'h2: row = {2'b10, 48'h04_04_01_01_08_08, 8'h00, 9'd160};
      4'h3: row = {2'b10, 48'h04_04_05_04_0A_0A, 8'h00, 9'd200};
      4'h4: row = {2'b11, 48'h03_04_02_01_0C_0C, 8'h80, 9'd264};
      4'h5: row = {2'b11, 48'h02_04_02_01_08_08, 8'h80, 9'd264};
      4'h6: row = {2'b11, 48'h06_04_02_02_0C_0C, 8'h80, 9'd132};
      4'h7: row = {2'b11, 48'h04_04_01_01_08_08, 8'h00, 9'd132};
      4'h8: row = {2'b11, 48'h04_04_03_02_0C_0C, 8'h00, 9'd198};
      4'h9: row = {2'b10, 48'h08_04_01_02_08_08, 8'h00, 9'd80};
      4'hA: row = {2'b10, 48'h08_08_05_04_0A_0A, 8'h00, 9'd100};
      4'hE: row = {2'b11, 48'h08_08_03_02_0C_0C, 8'h00, 9'd99};
      default: row = '0;
    endcase
  end

  // K of 256 does not fit eight bits; zero there stands for 256
  assign {valid_o, enc64_o} = row[66:65];
  assign {lanes_o, conv_o, octets_o, samples_o} = row[64:33];
  assign {res_o, bits_o} = row[32:17];
  assign k64_o = row[16:9];
  assign r_x16_o = row[R_W-1:0];

endmodule // link_mode_table

// file: design/mode_cfg_pkg.sv
package mode_cfg_pkg;

  // Word index width of the register bus (byte address bits 11:2)
  localparam int IDX_W = 10;
  localparam int DAT_W = 32;

  // Register word indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_SOFT_TRIG = 10'h06C;
  localparam logic [IDX_W-1:0] IDX_TRIM1 = 10'h037;
  localparam logic [IDX_W-1:0] IDX_TRIM2 = 10'h29A;
  localparam logic [IDX_W-1:0] IDX_TRIM3 = 10'h29B;
  localparam logic [IDX_W-1:0] IDX_TRIM4 = 10'h29C;
  localparam logic [IDX_W-1:0] IDX_CTRL = 10'h300;
  localparam logic [IDX_W-1:0] IDX_MODE = 10'h301;
  localparam logic [IDX_W-1:0] IDX_KM1 = 10'h302;
  localparam logic [IDX_W-1:0] IDX_DID = 10'h303;
  localparam logic [IDX_W-1:0] IDX_STATUS = 10'h304;

  // Power trim values: high-performance (reset) and low-power
  localparam logic [7:0] TRIM1_HP = 8'h4B;
  localparam logic [7:0] TRIM2_HP = 8'h0F;
  localparam logic [7:0] TRIM3_HP = 8'h04;
  localparam logic [7:0] TRIM4_HP = 8'h1B;
  localparam logic [7:0] TRIM1_LP = 8'h46;
  localparam logic [7:0] TRIM2_LP = 8'h06;
  localparam logic [7:0] TRIM3_LP = 8'h00;
  localparam logic [7:0] TRIM4_LP = 8'h14;

  // Control register bit positions
  localparam int CTRL_LINK_EN = 0;
  localparam int CTRL_CAL_EN = 1;
  localparam int CTRL_CAL_BG = 2;
  localparam int CTRL_LOW_PWR_BG = 3;
  localparam int CTRL_TRIG_EN = 4;
  localparam int CTRL_SCR = 5;
  localparam int CTRL_W = 6;

  // Status register field positions
  localparam int ST_VALID = 0;
  localparam int ST_ENC64 = 1;
  localparam int ST_PENDING = 2;
  localparam int ST_CSUM_LSB = 8;
  localparam int ST_R_LSB = 16;

  // Link layout
  localparam int MODE_W = 4;
  localparam int LANES = 8;
  localparam int R_W = 9; // lane bits per sample clock, in sixteenths

  // Fixed alignment fields
  localparam logic [7:0] JESDV_VAL = 8'h01;
  localparam logic [7:0] SUBCLASSV_VAL = 8'h01;
  localparam logic [7:0] CS_ILAS = 8'h00;
  localparam logic [7:0] ONE8 = 8'h01;
  localparam logic [7:0] E_FIXED = 8'h01;

  // Core switch delay after a trigger, in sample clocks
  localparam int SWITCH_MIN = 500;
  localparam int SWITCH_MAX = 1000;
  localparam int CNT_W = 10;
  localparam logic [CNT_W-1:0] SWITCH_DELAY =
    CNT_W'((SWITCH_MIN + SWITCH_MAX) / 2);

endpackage

// file: design/mode_config_ilas_params.sv
`timescale 1ns/1ps
// How it works
// - Power trims reset to high-performance values
// - Glitch trim sets core-switch glitch size
// - Triggered core switch 500-1000 samples later
// - Foreground calibration never switches cores
// - One mode field derives L, M, F, S, N, N' and R
// - R sets serializer PLL multiplication
// - E fixed at one in 64B/66B
// - Alignment parameters sent only in 8B/10B
// - Fixed zero and one alignment fields
// - Control bits field sent as zero
// - DID, SCR from user registers; K too in 8B/10B
// - Each lane reports its own lane id
// - M is packing count, not channel count
// - Checksum is field sum modulo 256
// - Link held reset while enable low
module mode_config_ilas_params (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Classic Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [11:2] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [mode_cfg_pkg::DAT_W-1:0] dat_i,
  output logic [mode_cfg_pkg::DAT_W-1:0] dat_o,
  output logic ack_o,
  // Calibration
  input wire logic calibration_trigger_ball_i,
  output logic cal_enable_o,
  output logic cal_background_o,
  output logic core_switch_o,
  output logic [7:0] power_trim_first_o,
  output logic [7:0] power_trim_second_o,
  output logic [7:0] power_trim_glitch_o,
  output logic [7:0] power_trim_fourth_o,
  // Link control
  output logic link_reset_o,
  output logic serializer_powerdown_o,
  output logic link_clock_enable_o,
  output logic [mode_cfg_pkg::R_W-1:0] pll_mult_x16_o,
  output logic enc64_o,
  output logic ilas_send_o,
  // Transport and alignment parameters
  output logic [7:0] lanes_o,
  output logic [7:0] converters_o,
  output logic [7:0] octets_o,
  output logic [7:0] samples_o,
  output logic [7:0] resolution_o,
  output logic [7:0] sample_bits_o,
  output logic [8:0] frames_per_multiframe_o,
  output logic [7:0] multiblocks_o,
  output logic [7:0] device_id_o,
  output logic scrambler_o,
  output logic [8*mode_cfg_pkg::LANES-1:0] lane_id_o,
  output logic [8*mode_cfg_pkg::LANES-1:0] ilas_checksum_o
);
  import mode_cfg_pkg::*;

  // Software state
  logic [7:0] trim1_reg; // First power trim
  logic [7:0] trim2_reg; // Second power trim
  logic [7:0] trim3_reg; // Glitch size trim
  logic [7:0] trim4_reg; // Fourth power trim
  logic [CTRL_W-1:0] ctrl_reg; // Enables and modes
  logic [MODE_W-1:0] mode_reg; // link_mode_select
  logic [7:0] km1_reg; // frames_per_multiframe_minus_one
  logic [7:0] did_reg; // Device identifier

  // Bus decode
  logic req; // Access seen this cycle
  logic wr_lane0; // Byte lane 0 written
  logic link_on; // Link enabled
  logic params_open; // Link parameters writable
  logic soft_trig; // Write to software trigger
  logic [DAT_W-1:0] rd_next; // Read data for this address
  logic [DAT_W-1:0] status; // Status word

  // Derived parameters
  logic mode_valid;
  logic enc64;
  logic [7:0] tl_l, tl_m, tl_f, tl_s, tl_n, tl_np, tl_k64;
  logic [R_W-1:0] tl_r;

  // Trigger path
  logic ball_reg; // Ball level one cycle ago
  logic ball_rise; // Ball rising edge
  logic arm; // Triggered switching allowed
  logic pending;
  logic switch_pulse;

  // Checksum of the fields common to every lane
  logic [7:0] csum_base;

  // A request is taken while ack is low; the ack that follows
  // blocks a second take, so one strobe is one access
  assign req = cyc_i && stb_i && !ack_o;
  // Writes land at the edge where the master sees ack high, so a
  // master that drops out before the answer changes nothing
  assign wr_lane0 = cyc_i && stb_i && ack_o && we_i && sel_i[0];
  assign link_on = ctrl_reg[CTRL_LINK_EN];
  // Parameters are frozen while the link runs
  assign params_open = !link_on;
  assign soft_trig = wr_lane0 && (adr_i == IDX_SOFT_TRIG);

  // Wishbone ack: one cycle after the request, dropped after one
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else if (ce_i) begin
      ack_o <= req;
    end
  end

  // Power trims come up in high-performance settings
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trim1_reg <= TRIM1_HP;
      trim2_reg <= TRIM2_HP;
      trim3_reg <= TRIM3_HP;
      trim4_reg <= TRIM4_HP;
    end else if (ce_i && wr_lane0) begin
      // Writes accepted at any time; quiet state is up to the host
      case (adr_i)
        IDX_TRIM1: trim1_reg <= dat_i[7:0];
        IDX_TRIM2: trim2_reg <= dat_i[7:0];
        IDX_TRIM3: trim3_reg <= dat_i[7:0];
        IDX_TRIM4: trim4_reg <= dat_i[7:0];
        default: ;
      endcase
    end
  end

  // Control register, always writable so the link can be stopped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= '0;
    end else if (ce_i && wr_lane0 && adr_i == IDX_CTRL) begin
      ctrl_reg <= dat_i[CTRL_W-1:0];
    end
  end

  // KM1 is kept in 64B/66B modes too; the checksum still sums it
  // Link parameters; writes ignored while link is enabled
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_reg <= '0;
      km1_reg <= '0;
      did_reg <= '0;
    end else if (ce_i && wr_lane0 && params_open) begin
      case (adr_i)
        IDX_MODE: mode_reg <= dat_i[MODE_W-1:0];
        IDX_KM1: km1_reg <= dat_i[7:0];
        IDX_DID: did_reg <= dat_i[7:0];
        default: ;
      endcase
    end
  end

  // Pending lets software wait out a scheduled core switch
  // Status word for software
  always_comb begin
    status = '0;
    status[ST_VALID] = mode_valid;
    status[ST_ENC64] = enc64;
    status[ST_PENDING] = pending;
    status[ST_CSUM_LSB +: 8] = ilas_checksum_o[7:0];
    status[ST_R_LSB +: R_W] = tl_r;
  end

  // Read mux; unmapped and write-only words read zero
  always_comb begin
    rd_next = '0;
    case (adr_i)
      IDX_TRIM1: rd_next[7:0] = trim1_reg;
      IDX_TRIM2: rd_next[7:0] = trim2_reg;
      IDX_TRIM3: rd_next[7:0] = trim3_reg;
      IDX_TRIM4: rd_next[7:0] = trim4_reg;
      IDX_CTRL: rd_next[CTRL_W-1:0] = ctrl_reg;
      IDX_MODE: rd_next[MODE_W-1:0] = mode_reg;
      IDX_KM1: rd_next[7:0] = km1_reg;
      IDX_DID: rd_next[7:0] = did_reg;
      IDX_STATUS: rd_next = status;
      default: rd_next = '0;
    endcase
  end

  // Registered read data costs one wait state but keeps dat_o
  // free of decode glitches
  // Read data register, loaded with the ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= '0;
    end else if (ce_i && req && !we_i) begin
      dat_o <= rd_next;
    end
  end

  // Mode lookup; M is a packing count, not the channel count
  link_mode_table u_table (
    .mode_i(mode_reg),
    .valid_o(mode_valid),
    .enc64_o(enc64),
    .lanes_o(tl_l),
    .conv_o(tl_m),
    .octets_o(tl_f),
    .samples_o(tl_s),
    .res_o(tl_n),
    .bits_o(tl_np),
    .k64_o(tl_k64),
    .r_x16_o(tl_r)
  );

  // Reset value matches the idle low pin, so no false edge
  // Ball edge detect; inputs are synchronous to the clock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ball_reg <= 1'b0;
    end else if (ce_i) begin
      ball_reg <= calibration_trigger_ball_i;
    end
  end
  assign ball_rise = calibration_trigger_ball_i && !ball_reg;

  // Only low-power background calibration switches on trigger;
  // foreground leaves arm low so no switch is ever made
  assign arm = ctrl_reg[CTRL_CAL_EN] && ctrl_reg[CTRL_CAL_BG]
    && ctrl_reg[CTRL_LOW_PWR_BG] && ctrl_reg[CTRL_TRIG_EN];

  core_switch_timer u_switch (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .arm_i(arm),
    .trigger_i(ball_rise || soft_trig),
    .pending_o(pending),
    .switch_o(switch_pulse)
  );
  assign core_switch_o = switch_pulse;

  // Calibration and trim outputs
  assign cal_enable_o = ctrl_reg[CTRL_CAL_EN];
  assign cal_background_o = ctrl_reg[CTRL_CAL_BG];
  assign power_trim_first_o = trim1_reg;
  assign power_trim_second_o = trim2_reg;
  assign power_trim_glitch_o = trim3_reg;
  assign power_trim_fourth_o = trim4_reg;

  // Link block held in reset, powered down and gated while off
  assign link_reset_o = !link_on;
  assign serializer_powerdown_o = !link_on;
  assign link_clock_enable_o = link_on;
  assign pll_mult_x16_o = tl_r;
  assign enc64_o = enc64;
  assign ilas_send_o = mode_valid && !enc64;

  // Transport parameters are the same set in both encodings
  assign lanes_o = tl_l;
  assign converters_o = tl_m;
  assign octets_o = tl_f;
  assign samples_o = tl_s;
  assign resolution_o = tl_n;
  assign sample_bits_o = tl_np;
  assign device_id_o = did_reg;
  assign scrambler_o = ctrl_reg[CTRL_SCR];

  // K: user field in 8B/10B, table value in 64B/66B
  assign frames_per_multiframe_o = enc64
    ? {tl_k64 == 8'h00, tl_k64}
    : {1'b0, km1_reg} + 9'h001;
  // E is one in 64B/66B and unused otherwise
  assign multiblocks_o = enc64 ? E_FIXED : 8'h00;

  // Minus-one fields are summed in the form sent on the wire
  // Sum of the shared fields; zero fields add nothing
  assign csum_base = did_reg + 8'(ctrl_reg[CTRL_SCR])
    + (tl_l - ONE8) + (tl_f - ONE8) + km1_reg
    + (tl_m - ONE8) + (tl_n - ONE8) + (tl_np - ONE8)
    + (tl_s - ONE8) + CS_ILAS
    + JESDV_VAL + SUBCLASSV_VAL;

  // One register stage per lane; the host leaves at least a cycle
  // between the last field write and the link enable
  // Per-lane id and checksum, registered so they follow the fields
  for (genvar g = 0; g < LANES; g++) begin : g_lane
    localparam logic [7:0] LID = 8'(g);
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        lane_id_o[8*g +: 8] <= '0;
        ilas_checksum_o[8*g +: 8] <= '0;
      end else if (ce_i) begin
        lane_id_o[8*g +: 8] <= LID;
        ilas_checksum_o[8*g +: 8] <= csum_base + LID;
      end
    end
  end

endmodule // mode_config_ilas_params

// file: tb/link_rx_model.sv
`timescale 1ns/1ps
module link_rx_model (
  input wire logic ilas_send_i,
  input wire logic [7:0] lanes_i,
  input wire logic [7:0] conv_i,
  input wire logic [7:0] octets_i,
  input wire logic [7:0] samples_i,
  input wire logic [7:0] res_i,
  input wire logic [7:0] bits_i,
  input wire logic [8:0] k_i,
  input wire logic [7:0] did_i,
  input wire logic scr_i,
  input wire logic [63:0] lane_id_i,
  input wire logic [63:0] csum_i,
  output logic csum_err_o
);
  // Receiver rebuilds each used lane's checksum from advertised fields;
  // conv_i is the packing count it de-interleaves
  always_comb begin
    csum_err_o = 1'b0;
    for (int g = 0; g < 8; g++) begin
      // Unused lanes carry no alignment sequence
      if (ilas_send_i && 8'(g) < lanes_i && csum_i[8*g +: 8] !==
          8'(did_i + {7'h00, scr_i} + lanes_i + octets_i + k_i[7:0]
          + conv_i + res_i + bits_i + samples_i + lane_id_i[8*g +: 8]
          + 8'hFB))
        csum_err_o = 1'b1;
    end
  end
endmodule // link_rx_model

// file: tb/mode_cfg_assertions.sv
`timescale 1ns/1ps
module mode_cfg_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cal_background_o,
  input wire logic core_switch_o,
  input wire logic [7:0] power_trim_first_o,
  input wire logic [7:0] power_trim_glitch_o,
  input wire logic link_reset_o,
  input wire logic serializer_powerdown_o,
  input wire logic link_clock_enable_o,
  input wire logic enc64_o,
  input wire logic ilas_send_o,
  input wire logic [7:0] lanes_o,
  input wire logic [7:0] converters_o,
  input wire logic [7:0] octets_o,
  input wire logic [7:0] samples_o,
  input wire logic [7:0] resolution_o,
  input wire logic [7:0] sample_bits_o,
  input wire logic [8:0] frames_per_multiframe_o,
  input wire logic [7:0] multiblocks_o,
  input wire logic [7:0] device_id_o,
  input wire logic scrambler_o,
  input wire logic [63:0] lane_id_o,
  input wire logic [63:0] ilas_checksum_o
);
  // Lane 0 sum; minus-one fields and the two fixed ones fold into FB
  logic [7:0] sum0;
  assign sum0 = device_id_o + {7'h00, scrambler_o} + lanes_o + octets_o
    + frames_per_multiframe_o[7:0] + converters_o + resolution_o
    + sample_bits_o + samples_o + 8'hFB;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_trim_reset: assert property (
    $fell(rst_i) |-> power_trim_first_o == 8'h4B
      && power_trim_glitch_o == 8'h04) else $error("trim reset value");
  chk_link_hold: assert property (
    link_reset_o == serializer_powerdown_o
      && link_reset_o == !link_clock_enable_o) else $error("link hold");
  chk_switch_bg: assert property (
    core_switch_o |-> cal_background_o) else $error("foreground switch");
  chk_switch_gap: assert property (
    core_switch_o |=> !core_switch_o [*8]) else $error("switch too soon");
  chk_e_fixed: assert property (
    lanes_o != 8'h00 |-> multiblocks_o == {7'h00, enc64_o})
    else $error("multiblock count");
  chk_ilas_enc: assert property (
    ilas_send_o |-> !enc64_o && lanes_o != 8'h00) else $error("ilas enc");
  chk_k_fixed: assert property (
    enc64_o |-> frames_per_multiframe_o inside {9'h080, 9'h100})
    else $error("K in 64B mode");
  chk_lane_ids: assert property (
    !$past(rst_i) |-> lane_id_o == 64'h0706050403020100)
    else $error("lane ids");
  chk_csum_lane0: assert property (
    !$past(rst_i) && $stable(sum0) && ilas_send_o
      |-> ilas_checksum_o[7:0] == sum0) else $error("lane 0 checksum");

  // Main scenarios reached
  cover property (core_switch_o);
  cover property (ilas_send_o ##1 enc64_o);
  cover property ($fell(link_reset_o));
endmodule // mode_cfg_checker

bind mode_config_ilas_params mode_cfg_checker chk_u (
  .clk_i, .rst_i, .cal_background_o, .core_switch_o, .power_trim_first_o,
  .power_trim_glitch_o, .link_reset_o, .serializer_powerdown_o,
  .link_clock_enable_o, .enc64_o, .ilas_send_o, .lanes_o, .converters_o,
  .octets_o, .samples_o, .resolution_o, .sample_bits_o,
  .frames_per_multiframe_o, .multiblocks_o, .device_id_o, .scrambler_o,
  .lane_id_o, .ilas_checksum_o);

// file: tb/testbench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin errors++; \
  $display("ERROR t=%0t got %0h exp %0h", $time, (a), (b)); end end
module testbench;
  import mode_cfg_pkg::*;
  logic clk_i, rst_i, ce, cyc, stb, we, ball;
  logic [9:0] adr;
  logic [31:0] wdat, rd, dat_o, seed, r;
  logic ack_o, cal_en, cal_bg, sw, lrst, spd, lcke, enc, ilas, scr, err;
  logic [7:0] tr1, tr2, tr3, tr4, ln, cv, oc, sm, rs, bt, eb, did;
  logic [8:0] pll, kk, expk;
  logic [7:0] got;
  logic [63:0] lid, cs;
  logic [33:0] row;
  int errors, num_checks, n;

  // 40 MHz, far below 1 GSPS, so low-power trims are legal
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  mode_config_ilas_params dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
    .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hF),
    .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o),
    .calibration_trigger_ball_i(ball), .cal_enable_o(cal_en),
    .cal_background_o(cal_bg), .core_switch_o(sw),
    .power_trim_first_o(tr1), .power_trim_second_o(tr2),
    .power_trim_glitch_o(tr3), .power_trim_fourth_o(tr4),
    .link_reset_o(lrst), .serializer_powerdown_o(spd),
    .link_clock_enable_o(lcke), .pll_mult_x16_o(pll), .enc64_o(enc),
    .ilas_send_o(ilas), .lanes_o(ln), .converters_o(cv), .octets_o(oc),
    .samples_o(sm), .resolution_o(rs), .sample_bits_o(bt),
    .frames_per_multiframe_o(kk), .multiblocks_o(eb), .device_id_o(did),
    .scrambler_o(scr), .lane_id_o(lid), .ilas_checksum_o(cs));

  link_rx_model rx_u (.ilas_send_i(ilas), .lanes_i(ln), .conv_i(cv),
    .octets_i(oc), .samples_i(sm), .res_i(rs), .bits_i(bt), .k_i(kk),
    .did_i(did), .scr_i(scr), .lane_id_i(lid), .csum_i(cs),
    .csum_err_o(err));

  // Xorshift stream from a fixed start
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Nibbles L M F S N N', then R in sixteenths, then 64B flag
  function automatic logic [33:0] mode_row(input logic [3:0] m);
    case (m)
      4'h0: return {24'h8885CC, 9'h080, 1'b0};
      4'h1: return {24'h6422CC, 9'h0A0, 1'b0};
      4'h2: return {24'h441188, 9'h0A0, 1'b0};
      4'h3: return {24'h4454AA, 9'h0C8, 1'b0};
      4'h4: return {24'h3421CC, 9'h108, 1'b1};
      4'h5: return {24'h242188, 9'h108, 1'b1};
      4'h6: return {24'h6422CC, 9'h084, 1'b1};
      4'h7: return {24'h441188, 9'h084, 1'b1};
      4'h8: return {24'h4432CC, 9'h0C6, 1'b1};
      4'h9: return {24'h841288, 9'h050, 1'b0};
      4'hA: return {24'h8854AA, 9'h064, 1'b0};
      4'hE: return {24'h8832CC, 9'h063, 1'b1};
      default: return 34'h0; // Unsupported codes report zeros
    endcase
  endfunction

  // Classic single cycle; held until ack is sampled high at a rising edge
  task automatic wb(input logic w, input logic [9:0] a,
                    input logic [31:0] d);
    int t;
    t = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      t++;
    end while (ack_o !== 1'b1 && t < 20);
    if (ack_o !== 1'b1) begin
      errors++;
      report_and_stop();
    end else begin
      rd = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge clk_i);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Watchdog: the tests need well under 10000 cycles
  initial begin
    #500000;
    errors++;
    report_and_stop();
  end

  initial begin
    seed = 32'h000056AE;
    errors = 0;
    num_checks = 0;
    {rst_i, cyc, stb, we, ball, adr, wdat} = {1'b1, 4'h0, 10'h000, 32'h0};
    ce = 1'b1;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    // Defaults, write-only trigger and an unmapped write
    wb(1'b1, 10'h3C0 | 10'(rnd() & 32'h3F), rnd());
    wb(1'b0, IDX_TRIM1, 0);
    `CHK(rd, 32'h4B)
    wb(1'b0, IDX_TRIM2, 0);
    `CHK(rd, 32'h0F)
    wb(1'b0, IDX_TRIM3, 0);
    `CHK(rd, 32'h04)
    wb(1'b0, IDX_TRIM4, 0);
    `CHK(rd, 32'h1B)
    wb(1'b0, IDX_SOFT_TRIG, 0);
    `CHK(rd, 32'h0)
    $display("test defaults done");
    // Low power and back; calibration and link stay off meanwhile
    for (int p = 0; p < 2; p++) begin
      wb(1'b1, IDX_TRIM1, p ? 32'h4B : 32'h46);
      wb(1'b1, IDX_TRIM2, p ? 32'h0F : 32'h06);
      wb(1'b1, IDX_TRIM3, p ? 32'h04 : 32'h00);
      wb(1'b1, IDX_TRIM4, p ? 32'h1B : 32'h14);
      `CHK({tr1, tr2, tr3, tr4}, p ? 32'h4B0F041B : 32'h46060014)
    end
    $display("test trims done");
    // Every mode code with random K, identifier and scrambler
    for (int m = 0; m < 16; m++) begin
      r = rnd();
      wb(1'b1, IDX_CTRL, {26'h0, r[8], 5'h00});
      wb(1'b1, IDX_MODE, 32'(m));
      wb(1'b1, IDX_KM1, {24'h0, r[2:0], 5'h1F});
      wb(1'b1, IDX_DID, {24'h0, r[31:24]});
      @(posedge clk_i);
      row = mode_row(m[3:0]);
      for (int i = 0; i < 6; i++) begin
        got = 8'({ln, cv, oc, sm, rs, bt} >> (40 - 8 * i));
        `CHK(got, {4'h0, row[33 - 4 * i -: 4]})
      end
      if (row != 34'h0) begin
        // K from the written field in 8B/10B, fixed by mode in 64B/66B
        expk = {1'b0, r[2:0], 5'h1F} + 9'h001;
        if (row[0]) expk = (m < 7) ? 9'h080 : 9'h100;
        `CHK({enc, ilas}, {row[0], !row[0]})
        `CHK(pll, row[9:1])
        `CHK(eb, {7'h00, row[0]})
        `CHK(kk, expk)
        `CHK({did, scr}, {r[31:24], r[8]})
        `CHK(lid, 64'h0706050403020100)
        `CHK(err, 1'b0)
      end else `CHK(ilas, 1'b0)
    end
    $display("test modes done");
    // Link on: out of reset, parameter writes locked out
    wb(1'b1, IDX_MODE, 32'h2);
    wb(1'b1, IDX_CTRL, 32'h1);
    `CHK({lrst, spd, lcke}, 3'b001)
    wb(1'b1, IDX_MODE, 32'h5);
    wb(1'b0, IDX_MODE, 0);
    `CHK({rd[3:0], ln}, 12'h204)
    wb(1'b0, IDX_STATUS, 0);
    `CHK({rd[24:16], rd[2:0]}, {9'h0A0, 3'b001})
    wb(1'b1, IDX_CTRL, 32'h0);
    `CHK({lrst, spd, lcke}, 3'b110)
    $display("test link enable done");
    // Software trigger, ball trigger, then ball in foreground mode
    for (int t = 0; t < 3; t++) begin
      wb(1'b1, IDX_CTRL, t == 2 ? 32'h1A : 32'h1E);
      `CHK({cal_en, cal_bg}, t == 2 ? 2'b10 : 2'b11)
      // Enabled edges already gone by since the trigger edge
      n = (t == 0) ? 1 : 0;
      if (t == 0) begin
        wb(1'b1, IDX_SOFT_TRIG, rnd());
        // Clock enable low: no sample clocks, so the delay stands still
        ce <= 1'b0;
        repeat (300) @(posedge clk_i);
        ce <= 1'b1;
      end else begin
        ball <= 1'b1;
        @(posedge clk_i);
        ball <= 1'b0;
      end
      while (sw !== 1'b1 && n < 1100) begin
        @(negedge clk_i);
        n++;
      end
      @(posedge clk_i);
      // n is the delay in sample clocks plus one
      if (t < 2) `CHK(n >= 501 && n <= 1001, 1'b1)
      else `CHK(n, 1100)
    end
    wb(1'b1, IDX_CTRL, 32'h0);
    $display("test core switch done");
    report_and_stop();
  end
endmodule // testbench
